/* File: ddm_decoder.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - operand fields sit at bits 20..14 (X), 13..7 (Y), 6..0 (Z)
// - each operand field splits into pointer bits 6..3 and index bits 2..0
// - pointer 0 means register direct, 1..14 pointers r1..r14, 15 is illegal
// - index subfield names the post-increment index register
// - accumulator select: a0..a3, constants 0.0 and 1.0, format four, reserved
// - adder sign bit: 0 adds, 1 subtracts
// - product sign bit: 0 positive, 1 negated product
// - bit-reverse flag turns on carry-reverse pointer update
// - special function: conversion selector in bits 26..23, X field all zero
// - conversion selector decode; codes 8, 9 and 15 are reserved
// - high-byte load lands in bits 15..8, low byte cleared; store keeps source
// - low-byte load lands in bits 7..0, upper bits cleared; store keeps source
// - byte stores move 8 bits and leave the flags alone
// - register loads set n and z, clear v and c; 16 or 24 bits
// - extended stores write 24 bits
// - memory operands go through pointer r1..r22, sizes 32, 24, 16 or 8 bits
// - base register is the program counter or one of r1..r22
// - immediate config loads: 21 bits for I/O word, 5 bits for arithmetic word
// - direct index: a0..a3, input buffer, output buffer, parallel data, no write
module ddm_decoder
  import ddm_pkg::*;
#(
  parameter int ADDR_W = 24
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  output logic fetchReq,
  output logic [ADDR_W-1:0] fetchAddr,
  input wire logic insnValid,
  input wire logic [INSN_W-1:0] insnWord,
  input wire logic moveValid,
  input ddm_move_req_t moveReq,
  output ddm_da_t daOut,
  output ddm_move_out_t moveOut
);

  ////////////////////////////////////////////////////////////////////////////////
  if (ADDR_W < 1 || ADDR_W > 24) begin : g_bad_addr
    $error("ADDR_W must lie between 1 and 24");
  end

  typedef enum logic [0:0] {ST_IDLE, ST_RUN} ddm_fsm_t;

  typedef struct packed {
    ddm_fsm_t fsm;
    logic [ADDR_W-1:0] pc;
    ddm_da_t da;
    ddm_move_out_t mv;
  } ddm_state_t;

  ddm_state_t s;
  ddm_state_t next_s;
  ddm_da_t daDec;
  ddm_move_out_t moveDec;
  ddm_operand_t [2:0] opndDec;
  logic accepted;
  logic [2:0] opc;
  logic [2:0] mSel;

  ////////////////////////////////////////////////////////////////////////////////
  // operand field decoders, index 0 is Z, 2 is X
  for (genvar k = 0; k < 3; k++) begin : g_opnd
    ddm_operand_dec u_opnd (
      .field(insnWord[FLD_LO[k] +: FLD_W]),
      .role(ddm_role_t'(k)),
      .opnd(opndDec[k])
    );
  end

  ddm_move_unit u_move (
    .req(moveReq),
    .res(moveDec)
  );

  assign accepted = fetchReq && insnValid;
  assign opc = insnWord[OPC_LO +: 3];
  assign mSel = insnWord[M_LO +: 3];

  ////////////////////////////////////////////////////////////////////////////////
  // instruction field decode
  always_comb begin
    daDec = '0;
    daDec.accSel = ddm_acc_t'(mSel);
    daDec.conv = ddm_conv_t'(insnWord[G_LO +: 4]);
    daDec.subtract = insnWord[F_BIT];
    daDec.negProduct = insnWord[S_BIT];
    daDec.bitReverse = insnWord[R_BIT];
    daDec.accOut = insnWord[ACCN_LO +: 2];
    daDec.opnd = opndDec;
    case (opc)
      OPC_F1: daDec.fmt = (mSel == M_FMT4) ? FMT_4 : FMT_1;
      OPC_F2: daDec.fmt = FMT_2;
      OPC_F3: daDec.fmt = (mSel[2:1] == SF_TAG) ? FMT_5 : FMT_3;
      default: daDec.fmt = FMT_NONE;
    endcase
    case (daDec.fmt)
      FMT_1, FMT_3: begin
        daDec.illegal = (mSel == M_RSVD) || (|{opndDec[0].illegal, opndDec[1].illegal, opndDec[2].illegal});
      end
      FMT_2: begin
        daDec.illegal = (mSel >= M_FMT4) || (|{opndDec[0].illegal, opndDec[1].illegal, opndDec[2].illegal});
      end
      FMT_4: begin
        daDec.illegal = |{opndDec[0].illegal, opndDec[1].illegal, opndDec[2].illegal};
      end
      FMT_5: begin
        daDec.subtract = 1'b0;
        daDec.negProduct = 1'b0;
        daDec.bitReverse = 1'b0;
        daDec.opnd[2] = '0;
        daDec.illegal = ddmConvReserved(daDec.conv)
                        || (insnWord[X_LO +: FLD_W] != SF_X_ZERO)
                        || opndDec[0].illegal || opndDec[1].illegal;
      end
      default: daDec.illegal = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fetch sequencing and output registers
  always_comb begin
    next_s = s;
    next_s.da.valid = 1'b0;
    next_s.da.illegal = 1'b0;
    next_s.mv.valid = 1'b0;
    next_s.mv.illegal = 1'b0;
    case (s.fsm)
      ST_IDLE: next_s.fsm = ST_RUN;
      ST_RUN: begin
        if (accepted) begin
          next_s.pc = s.pc + 1'b1;
          if (daDec.fmt != FMT_NONE) begin
            next_s.da = daDec;
            next_s.da.valid = !daDec.illegal;
            next_s.da.illegal = daDec.illegal;
          end
        end
      end
      default: next_s.fsm = ST_IDLE;
    endcase
    if (moveValid) begin
      next_s.mv = moveDec;
      next_s.mv.valid = !moveDec.illegal;
      if (moveDec.illegal) begin
        next_s.mv.regWrite = 1'b0;
        next_s.mv.memRead = 1'b0;
        next_s.mv.memWrite = 1'b0;
        next_s.mv.flagsWrite = 1'b0;
        next_s.mv.ptrUpdate = 1'b0;
        next_s.mv.cfgWrite = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fetchReq = (s.fsm == ST_RUN);
  assign fetchAddr = s.pc;
  assign daOut = s.da;
  assign moveOut = s.mv;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  zfield_slice_a: assert property (
    accepted && opc == OPC_F1 && !daDec.illegal |=> daOut.opnd[0].ptrSel == $past(insnWord[6:3])
      && daOut.opnd[2].idxSel == $past(insnWord[16:14]))
    else $error("operand field slice wrong");

  ptr_illegal_a: assert property (
    accepted && opc == OPC_F2 && insnWord[13:10] == PTR_BAD |=> daOut.illegal && !daOut.valid)
    else $error("pointer code 15 accepted");

  direct_role_a: assert property (
    accepted && opc == OPC_F1 && insnWord[6:0] == 7'h04 |=> daOut.illegal)
    else $error("input buffer allowed as Z");

  acc_rsvd_a: assert property (
    accepted && opc == OPC_F1 && mSel == M_RSVD |=> !daOut.valid && daOut.illegal)
    else $error("reserved accumulator code accepted");

  sign_bits_a: assert property (
    accepted && opc == OPC_F2 |=> daOut.subtract == $past(insnWord[24])
      && daOut.negProduct == $past(insnWord[23]) && daOut.bitReverse == $past(insnWord[25]))
    else $error("sign or reverse bit mismatch");

  sf_xzero_a: assert property (
    accepted && opc == OPC_F3 && mSel[2:1] == SF_TAG && insnWord[20:14] != 7'h00 |=> daOut.illegal)
    else $error("nonzero X in special function");

  conv_rsvd_a: assert property (
    daOut.valid && daOut.fmt == FMT_5 |-> !ddmConvReserved(daOut.conv))
    else $error("reserved conversion code issued");

  byte_high_a: assert property (
    moveValid && moveReq.kind == MV_LD_HIGH && !moveDec.illegal |=> moveOut.regWrite
      && moveOut.regData == {8'h00, $past(moveReq.data[7:0]), 8'h00})
    else $error("high byte load misplaced");

  load_flags_a: assert property (
    moveOut.valid && moveOut.regWrite |-> moveOut.flagsWrite && !moveOut.flags.v && !moveOut.flags.c
      && moveOut.flags.z == (moveOut.regData == 24'h000000))
    else $error("load flags wrong");

  byte_store_a: assert property (
    moveValid && moveReq.kind == MV_ST_LOW && !moveDec.illegal |=> moveOut.memWrite
      && moveOut.size == SZ_8 && !moveOut.flagsWrite && !moveOut.regWrite)
    else $error("byte store wrong");

  ext_store_a: assert property (
    moveValid && moveReq.kind == MV_ST24 && !moveDec.illegal |=> moveOut.size == SZ_24
      && moveOut.memData[23:0] == $past(moveReq.data[23:0]))
    else $error("extended store wrong");

  suppress_a: assert property (
    moveOut.illegal |-> !moveOut.regWrite && !moveOut.memWrite && !moveOut.cfgWrite && !moveOut.valid)
    else $error("illegal move had side effects");

  fetch_step_a: assert property (
    accepted |=> fetchAddr == $past(fetchAddr) + 1'b1)
    else $error("fetch address did not advance");

  sf_cover: cover property (accepted && daDec.fmt == FMT_5 && !daDec.illegal);
  fmt4_cover: cover property (accepted && daDec.fmt == FMT_4 && !daDec.illegal);
  ldhigh_cover: cover property (moveValid && moveReq.kind == MV_LD_HIGH && !moveDec.illegal);
  illegal_cover: cover property (daOut.illegal ##1 daOut.valid);

endmodule

/* File: ddm_pkg.sv */
package ddm_pkg;

  localparam int INSN_W = 32;
  localparam int FLD_W = 7;
  localparam int X_LO = 14;
  localparam int Y_LO = 7;
  localparam int Z_LO = 0;
  localparam int FLD_LO [3] = '{Z_LO, Y_LO, X_LO};
  localparam int PTR_LO = 3;
  localparam int PTR_W = 4;
  localparam int IDX_W = 3;
  localparam logic [3:0] PTR_DIRECT = 4'h0;
  localparam logic [3:0] PTR_BAD = 4'hF;

  localparam int OPC_LO = 29;
  localparam logic [2:0] OPC_F1 = 3'h1;
  localparam logic [2:0] OPC_F2 = 3'h2;
  localparam logic [2:0] OPC_F3 = 3'h3;
  localparam int M_LO = 26;
  localparam logic [2:0] M_FMT4 = 3'h6;
  localparam logic [2:0] M_RSVD = 3'h7;
  localparam logic [1:0] SF_TAG = 2'h3;
  localparam int R_BIT = 25;
  localparam int F_BIT = 24;
  localparam int S_BIT = 23;
  localparam int ACCN_LO = 21;
  localparam int G_LO = 23;
  localparam logic [FLD_W-1:0] SF_X_ZERO = 7'h00;

  localparam logic [4:0] REG_MIN = 5'h01;
  localparam logic [4:0] REG_MAX = 5'h16;
  localparam logic [4:0] REG_PC = 5'h00;
  localparam int IOC_W = 21;
  localparam int DAUC_W = 5;
  localparam logic [1:0] RST_FETCH = 2'h0;

  typedef enum logic [2:0] {ACC_A0, ACC_A1, ACC_A2, ACC_A3, ACC_ZERO, ACC_ONE, ACC_FMT4, ACC_RSVD} ddm_acc_t;
  typedef enum logic [3:0] {CV_IN, CV_OUT, CV_FLOAT, CV_INT, CV_ROUND, CV_IFALT, CV_IFAEQ, CV_IFAGT,
                            CV_RSV8, CV_RSV9, CV_FLOAT24, CV_INT24, CV_TOIEEE, CV_FROMIEEE, CV_SEED,
                            CV_RSVF} ddm_conv_t;
  typedef enum logic [2:0] {DR_A0, DR_A1, DR_A2, DR_A3, DR_IBUF, DR_OBUF, DR_PDR, DR_NOWRITE} ddm_direct_t;
  typedef enum logic [1:0] {ROLE_Z, ROLE_Y, ROLE_X} ddm_role_t;
  typedef enum logic [2:0] {FMT_NONE, FMT_1, FMT_2, FMT_3, FMT_4, FMT_5} ddm_fmt_t;
  typedef enum logic [3:0] {MV_NONE, MV_LD_HIGH, MV_LD_LOW, MV_LD16, MV_LD24, MV_ST_HIGH, MV_ST_LOW,
                            MV_ST16, MV_ST24, MV_XFER32, MV_IMM_IOC, MV_IMM_DAUC, MV_BASE} ddm_kind_t;
  typedef enum logic [2:0] {SZ_NONE, SZ_8, SZ_16, SZ_24, SZ_32} ddm_size_t;

  typedef struct packed {
    logic indirect;
    logic [PTR_W-1:0] ptrSel;
    logic [IDX_W-1:0] idxSel;
    ddm_direct_t direct;
    logic illegal;
  } ddm_operand_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    ddm_fmt_t fmt;
    ddm_acc_t accSel;
    ddm_conv_t conv;
    logic subtract;
    logic negProduct;
    logic bitReverse;
    logic [1:0] accOut;
    ddm_operand_t [2:0] opnd;
  } ddm_da_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } ddm_flags_t;

  typedef struct packed {
    ddm_kind_t kind;
    logic [4:0] regSel;
    logic viaPtr;
    logic [4:0] ptrSel;
    logic postInc;
    logic idxInc;
    logic [4:0] idxSel;
    logic [31:0] data;
  } ddm_move_req_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic regWrite;
    logic [4:0] regSel;
    logic [23:0] regData;
    logic memRead;
    logic memWrite;
    ddm_size_t size;
    logic [31:0] memData;
    logic flagsWrite;
    ddm_flags_t flags;
    logic ptrUpdate;
    logic [4:0] ptrSel;
    logic usesIdx;
    logic [4:0] idxSel;
    logic cfgWrite;
    logic cfgIsIoc;
    logic [IOC_W-1:0] cfgValue;
    logic baseIsPc;
  } ddm_move_out_t;

  function automatic logic ddmConvReserved(input ddm_conv_t cv);
    return (cv == CV_RSV8) || (cv == CV_RSV9) || (cv == CV_RSVF);
  endfunction

endpackage

/* File: ddm_operand_dec.sv */
`timescale 1ns/1ps
module ddm_operand_dec
  import ddm_pkg::*;
(
  input wire logic [FLD_W-1:0] field,
  input wire ddm_role_t role,
  output ddm_operand_t opnd
);

  always_comb begin
    opnd = '0;
    opnd.ptrSel = field[PTR_LO +: PTR_W];
    opnd.idxSel = field[IDX_W-1:0];
    opnd.indirect = (opnd.ptrSel != PTR_DIRECT);
    opnd.direct = ddm_direct_t'(opnd.idxSel);
    if (opnd.ptrSel == PTR_BAD) begin
      opnd.illegal = 1'b1;
    end else if (!opnd.indirect) begin
      case (opnd.direct)
        DR_A0, DR_A1, DR_A2, DR_A3, DR_IBUF: opnd.illegal = (role == ROLE_Z);
        DR_OBUF, DR_NOWRITE: opnd.illegal = (role != ROLE_Z);
        DR_PDR: opnd.illegal = (role == ROLE_X);
        default: opnd.illegal = 1'b1;
      endcase
    end
  end

endmodule

/* File: ddm_move_unit.sv */
`timescale 1ns/1ps
module ddm_move_unit
  import ddm_pkg::*;
(
  input ddm_move_req_t req,
  output ddm_move_out_t res
);

  function automatic logic regOk(input logic [4:0] sel);
    return (sel >= REG_MIN) && (sel <= REG_MAX);
  endfunction

  always_comb begin
    res = '0;
    res.regSel = req.regSel;
    res.ptrSel = req.ptrSel;
    res.idxSel = req.idxSel;
    case (req.kind)
      MV_LD_HIGH: res.regData = {8'h00, req.data[7:0], 8'h00};
      MV_LD_LOW: res.regData = {16'h0000, req.data[7:0]};
      MV_LD16: res.regData = {8'h00, req.data[15:0]};
      MV_LD24: res.regData = req.data[23:0];
      MV_ST_HIGH: res.memData = {24'h000000, req.data[15:8]};
      MV_ST_LOW: res.memData = {24'h000000, req.data[7:0]};
      MV_ST16: res.memData = {16'h0000, req.data[15:0]};
      MV_ST24: res.memData = {8'h00, req.data[23:0]};
      MV_XFER32: res.memData = req.data;
      MV_IMM_IOC: res.cfgValue = req.data[IOC_W-1:0];
      MV_IMM_DAUC: res.cfgValue = {16'h0000, req.data[DAUC_W-1:0]};
      default: res.regData = '0;
    endcase
    case (req.kind)
      MV_LD_HIGH, MV_LD_LOW, MV_LD16, MV_LD24: begin
        res.regWrite = 1'b1;
        res.memRead = 1'b1;
        res.flagsWrite = 1'b1;
        res.flags.n = (req.kind == MV_LD24) ? res.regData[23] : res.regData[15];
        res.flags.z = (res.regData == 24'h000000);
        res.illegal = !regOk(req.regSel);
      end
      MV_ST_HIGH, MV_ST_LOW, MV_ST16, MV_ST24: begin
        res.memWrite = 1'b1;
        res.illegal = !regOk(req.regSel);
      end
      MV_XFER32: begin
        res.memWrite = 1'b1;
        res.memRead = 1'b1;
      end
      MV_IMM_IOC, MV_IMM_DAUC: begin
        res.cfgWrite = 1'b1;
        res.cfgIsIoc = (req.kind == MV_IMM_IOC);
      end
      MV_BASE: begin
        res.baseIsPc = (req.regSel == REG_PC);
        res.illegal = !res.baseIsPc && !regOk(req.regSel);
      end
      default: res.illegal = 1'b0;
    endcase
    case (req.kind)
      MV_LD_HIGH, MV_LD_LOW, MV_ST_HIGH, MV_ST_LOW: res.size = SZ_8;
      MV_LD16, MV_ST16: res.size = SZ_16;
      MV_LD24, MV_ST24: res.size = SZ_24;
      MV_XFER32: res.size = SZ_32;
      default: res.size = SZ_NONE;
    endcase
    if ((res.memRead || res.memWrite) && req.viaPtr) begin
      res.ptrUpdate = req.postInc || req.idxInc;
      res.usesIdx = req.idxInc;
      if (!regOk(req.ptrSel) || (req.idxInc && !regOk(req.idxSel))) begin
        res.illegal = 1'b1;
      end
    end
  end

endmodule

/* File: ddm_prog_mem.sv */
`timescale 1ns/1ps
module ddm_prog_mem
  import ddm_pkg::*;
#(
  parameter int AW = 4
)
(
  input wire logic fetchReq,
  input wire logic [AW-1:0] fetchAddr,
  input wire logic stall,
  output logic insnValid,
  output logic [INSN_W-1:0] insnWord
);
  logic [INSN_W-1:0] words [2**AW];
  initial begin
    foreach (words[i]) words[i] = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////
  // answers when asked unless stalled; idle word is scrambled
  assign insnValid = fetchReq && !stall;
  assign insnWord = insnValid ? words[fetchAddr] : ~words[fetchAddr];
endmodule

/* File: dsp_insn_decode_datamove_test.sv */
`timescale 1ns/1ps
module dsp_insn_decode_datamove_test;
  import ddm_pkg::*;
  localparam int AW = 4;
  logic ref_clk, rst_b, stall, fetchReq, insnValid, moveValid, pend;
  logic [AW-1:0] fetchAddr, expAddr;
  logic [INSN_W-1:0] insnWord, pendW;
  logic [31:0] t;
  logic [15:0] lfsr;
  logic [31:0] prog [$];
  ddm_move_req_t moveReq;
  ddm_da_t daOut;
  ddm_move_out_t moveOut;
  int errorCnt, comparisons, taken;
  ddm_kind_t kl [12] = '{MV_LD_HIGH, MV_LD_LOW, MV_LD16, MV_LD24, MV_ST_HIGH, MV_ST_LOW, MV_ST16, MV_ST24,
                         MV_XFER32, MV_IMM_IOC, MV_IMM_DAUC, MV_BASE};

  ddm_decoder #(.ADDR_W(AW)) ddm_decoder_i (.ref_clk(ref_clk), .rst_b(rst_b), .fetchReq(fetchReq),
    .fetchAddr(fetchAddr), .insnValid(insnValid), .insnWord(insnWord), .moveValid(moveValid),
    .moveReq(moveReq), .daOut(daOut), .moveOut(moveOut));
  ddm_prog_mem #(.AW(AW)) ddm_prog_mem_i (.fetchReq(fetchReq), .fetchAddr(fetchAddr), .stall(stall),
    .insnValid(insnValid), .insnWord(insnWord));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      r = {r[30:0], lfsr[0]};
    end
    return r;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errorCnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // reference decode of one instruction word
  task automatic checkDa(input logic [31:0] w);
    logic [2:0] opc, m;
    logic f5, ill;
    logic [6:0] f;
    ddm_fmt_t fm;
    opc = w[31:29];
    m = w[28:26];
    f5 = opc == 3'h3 && w[28:27] == 2'h3;
    ill = f5 ? (w[20:14] != SF_X_ZERO || w[26:23] inside {4'h8, 4'h9, 4'hF}) : (m == 3'h7 || (opc == 3'h2 && m == 3'h6));
    fm = f5 ? FMT_5 : opc == 3'h1 ? (m == M_FMT4 ? FMT_4 : FMT_1) : opc == 3'h2 ? FMT_2 : FMT_3;
    for (int r = 0; r < 3; r++) begin
      f = w[7*r +: 7];
      if (!(f5 && r == 2))
        ill |= f[6:3] == PTR_BAD || (f[6:3] == PTR_DIRECT &&
          (r == 2 ? f[2:0] > 3'h4 : r == 1 ? f[2:0] inside {3'h5, 3'h7} : f[2:0] < 3'h5));
    end
    if (opc == 3'h0 || opc > 3'h3) begin
      chk("da pulse", 0, {daOut.valid, daOut.illegal});
    end else begin
      chk("da flags", {!ill, ill}, {daOut.valid, daOut.illegal});
      if (!ill) begin
        chk("fmt", fm, daOut.fmt);
        chk("acc out", w[22:21], daOut.accOut);
        chk("signs", f5 ? 3'h0 : w[25:23], {daOut.bitReverse, daOut.subtract, daOut.negProduct});
        if (f5) chk("conv", w[26:23], daOut.conv);
        else chk("acc sel", m, daOut.accSel);
        for (int r = 0; r < 3; r++) begin
          f = w[7*r +: 7];
          if (!(f5 && r == 2)) begin
            chk("mode", f[6:3] != 4'h0, daOut.opnd[r].indirect);
            if (f[6:3] != 4'h0) chk("ptr idx", f, {daOut.opnd[r].ptrSel, daOut.opnd[r].idxSel});
            else chk("direct", f[2:0], daOut.opnd[r].direct);
          end
        end
      end
    end
  endtask

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend = 1'b0;
      expAddr = '0;
    end else begin
      pend = fetchReq && insnValid;
      pendW = insnWord;
      if (pend) begin
        expAddr = expAddr + 1'b1;
        taken++;
      end
    end
  end

  always @(negedge ref_clk) begin
    if (rst_b) begin
      chk("fetch addr", expAddr, fetchAddr);
      if (pend) checkDa(pendW);
      else chk("da idle", 0, {daOut.valid, daOut.illegal});
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic runProg(input logic slow);
    int n, k;
    while (prog.size() > 0) begin
      n = prog.size() > 16 ? 16 : prog.size();
      for (int i = 0; i < n; i++) ddm_prog_mem_i.words[AW'(fetchAddr + i)] = prog.pop_front();
      k = taken + n;
      for (int c = 0; c < 200 && taken < k; c++) begin
        stall = slow && rnd() > 32'h7FFFFFFF;
        @(negedge ref_clk);
      end
      if (taken < k) chk("batch taken", k, taken);
      stall = 1'b1;
    end
  endtask

  task automatic mv(input ddm_kind_t k, input logic [4:0] rs, input logic vp, input logic [4:0] ps, input logic [31:0] d);
    logic ld, st, x, ill, mem;
    logic [23:0] rd;
    logic [31:0] md, u;
    ddm_size_t sz;
    u = rnd();
    moveValid = 1'b1;
    moveReq = '{kind: k, regSel: rs, viaPtr: vp, ptrSel: ps, postInc: u[0], idxInc: u[1],
                idxSel: 5'(1 + u[8:4] % 22), data: d};
    ld = k inside {MV_LD_HIGH, MV_LD_LOW, MV_LD16, MV_LD24};
    st = k inside {MV_ST_HIGH, MV_ST_LOW, MV_ST16, MV_ST24};
    x = k == MV_XFER32;
    mem = ld || st || x;
    ill = ((ld || st) && (rs == 5'h00 || rs > REG_MAX)) || (mem && vp && (ps == 5'h00 || ps > REG_MAX)) ||
          (k == MV_BASE && rs > REG_MAX);
    sz = SZ_32;
    case (k)
      MV_LD_HIGH: begin rd = {8'h00, d[7:0], 8'h00}; sz = SZ_8; end
      MV_LD_LOW: begin rd = {16'h0000, d[7:0]}; sz = SZ_8; end
      MV_LD16: begin rd = {8'h00, d[15:0]}; sz = SZ_16; end
      MV_LD24: begin rd = d[23:0]; sz = SZ_24; end
      MV_ST_HIGH: begin md = {24'h000000, d[15:8]}; sz = SZ_8; end
      MV_ST_LOW: begin md = {24'h000000, d[7:0]}; sz = SZ_8; end
      MV_ST16: begin md = {16'h0000, d[15:0]}; sz = SZ_16; end
      MV_ST24: begin md = {8'h00, d[23:0]}; sz = SZ_24; end
      default: md = d;
    endcase
    @(negedge ref_clk);
    chk("mv flags", {ill, !ill}, {moveOut.illegal, moveOut.valid});
    chk("mv strobes", ill ? 4'h0 : {ld, ld || x, st || x, ld},
        {moveOut.regWrite, moveOut.memRead, moveOut.memWrite, moveOut.flagsWrite});
    if (!ill) begin
      if (ld) chk("mv load", {rd, k == MV_LD24 ? rd[23] : rd[15], rd == 24'h0, 2'h0},
                  {moveOut.regData, moveOut.flags});
      if (ld || st || x) chk("mv size", sz, moveOut.size);
      if (st) chk("mv store", md, moveOut.memData);
      if (k == MV_IMM_IOC || k == MV_IMM_DAUC)
        chk("mv cfg", {1'b1, k == MV_IMM_IOC, k == MV_IMM_IOC ? d[20:0] : {16'h0000, d[4:0]}},
            {moveOut.cfgWrite, moveOut.cfgIsIoc, moveOut.cfgValue});
      if (k == MV_BASE) chk("mv base", rs == REG_PC, moveOut.baseIsPc);
      chk("mv ptr", {mem && vp && (u[0] | u[1]), mem && vp && u[1], ps},
          {moveOut.ptrUpdate, moveOut.usesIdx, moveOut.ptrSel});
      chk("mv sel", {rs, moveReq.idxSel}, {moveOut.regSel, moveOut.idxSel});
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    errorCnt++;
    summarize();
  end

  initial begin
    rst_b = 1'b0;
    stall = 1'b1;
    moveValid = 1'b0;
    moveReq = '0;
    lfsr = 16'h0042;
    repeat (8) @(negedge ref_clk);
    chk("in reset", 0, |{fetchReq, fetchAddr, daOut, moveOut});
    rst_b = 1'b1;
    @(negedge ref_clk);
    chk("fetch on", 1, fetchReq);
    $display("test reset done");
    // every select code in three formats
    for (int o = 1; o < 4; o++) for (int m = 0; m < 8; m++) begin
      t = rnd();
      prog.push_back({3'(o), 3'(m), t[25:21], 7'h08, 7'h11, 7'h1A});
    end
    for (int g = 0; g < 16; g++) begin
      t = rnd();
      prog.push_back({5'h0F, 4'(g), 1'b1, t[0], 7'h00, 7'h11, 7'h1A});
    end
    prog.push_back({5'h0F, 4'h2, 2'h2, 7'h01, 7'h11, 7'h1A});
    // direct and forbidden pointer codes in each field
    for (int r = 0; r < 3; r++) for (int c = 0; c < 16; c++) begin
      t = {3'(r + 1), 3'h0, 5'h00, 7'h08, 7'h11, 7'h1A};
      t[7*r +: 7] = {c[3] ? PTR_BAD : PTR_DIRECT, 3'(c)};
      prog.push_back(t);
    end
    runProg(1'b0);
    $display("test directed decode done");
    for (int j = 0; j < 80; j++) begin
      t = rnd();
      t[31] = 1'b0;
      prog.push_back(t);
      if (j == 39) runProg(1'b0);
    end
    runProg(1'b1);
    $display("test random decode done");
    for (int j = 0; j < 24; j++) begin
      t = rnd();
      mv(kl[j % 12], 5'(1 + t[12:8] % 22), t[5], 5'(1 + t[20:16] % 22), rnd());
    end
    mv(MV_LD_LOW, 5'h01, 1'b0, 5'h00, 32'h0000FF00);
    mv(MV_LD16, 5'h16, 1'b0, 5'h00, 32'h00008000);
    mv(MV_LD24, 5'h02, 1'b1, 5'h16, 32'h00800000);
    mv(MV_ST16, 5'h17, 1'b0, 5'h00, 32'h00001234);
    mv(MV_LD_HIGH, 5'h00, 1'b0, 5'h00, 32'h000000AB);
    mv(MV_ST24, 5'h05, 1'b1, 5'h00, 32'h00ABCDEF);
    mv(MV_BASE, 5'h00, 1'b0, 5'h00, 32'h0);
    mv(MV_BASE, 5'h17, 1'b0, 5'h00, 32'h0);
    mv(MV_ST_HIGH, 5'h16, 1'b1, 5'h17, 32'h0000AB12);
    moveValid = 1'b0;
    $display("test moves done");
    @(negedge ref_clk);
    rst_b = 1'b0;
    @(negedge ref_clk);
    chk("mid reset", 0, |{fetchReq, fetchAddr, daOut, moveOut});
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    for (int j = 0; j < 20; j++) prog.push_back(rnd() & 32'h7FFFFFFF);
    runProg(1'b1);
    $display("test second reset done");
    summarize();
  end
endmodule
